// File: inc/eeprom_params.svh
`ifndef EEPROM_PARAMS_SVH
`define EEPROM_PARAMS_SVH
// Device-type code; value is arbitrary
`define DEV_CODE 4'h5
`define ADDR_W 8
`define PAGE_LOW_W 3
`define DATA_W 8
`define WRITE_CYCLES 16'h07d0
`define QUARTER_CYCLES 8'h04
`define FIFO_DEPTH 16
`define BYTE_LAST_BIT 4'h8
`define ACK_SLOT 4'h9
`endif

// File: inc/eeprom_pkg.sv
package eeprom_pkg;
	typedef enum logic [2:0] {
		T_IDLE = 3'b000,
		T_CTRL = 3'b001,
		T_ADDR = 3'b010,
		T_WDATA = 3'b011,
		T_RDATA = 3'b100,
		T_MACK = 3'b101
	} target_state_t;
	typedef enum logic [2:0] {
		M_IDLE = 3'b000,
		M_START = 3'b001,
		M_TX = 3'b010,
		M_RX = 3'b011,
		M_STOP = 3'b100
	} master_state_t;
	typedef enum logic [2:0] {
		SEQ_CTRLW = 3'b000,
		SEQ_ADDR = 3'b001,
		SEQ_DATA = 3'b010,
		SEQ_CTRLR = 3'b011,
		SEQ_READ = 3'b100
	} stage_t;
	typedef enum logic [1:0] {
		OP_WRITE = 2'b00,
		OP_CUR_READ = 2'b01,
		OP_RAND_READ = 2'b10,
		OP_POLL = 2'b11
	} op_t;
endpackage

// File: inc/eeprom_bus_if.sv
`timescale 1ns/1ps
interface eeprom_bus_if;
	logic scl;
	logic sda_m_o;
	logic sda_m_oe;
	logic sda_t_o;
	logic sda_t_oe;
	logic power_en;
	logic sda;
	// Open-drain data line with pull-up
	assign sda = !((sda_m_oe && !sda_m_o) || (sda_t_oe && !sda_t_o));
	modport master(output scl, output sda_m_o, output sda_m_oe, output power_en, input sda);
	modport target(input scl, input sda, input power_en, output sda_t_o, output sda_t_oe);
endinterface

// File: src/eeprom_target.sv
// Summary of operation
// - Write control byte: code, three ignored, low
// - Acknowledge each byte in ninth clock
// - Byte after write control loads pointer
// - Data byte acknowledged; STOP starts write
// - No acknowledge while write cycle runs
// - Up to eight bytes buffered until STOP
// - Only low three pointer bits increment on write
// - Ninth byte wraps, overwriting buffered bytes
// - Master repeats START and control until acknowledged
// - Acknowledge polling control once write ends
// - Read starts like write, bit high
// - Pointer holds last location plus one
// - Read control: acknowledge, send byte, stop
// - Repeated START keeps loaded word address
// - Random read: read control, nack, STOP
// - Master acknowledge requests next sequential byte
// - Pointer increments after each byte
// - START: data falls while clock high
// - STOP: data rises while clock high
// - Data changes only while clock low
// - Master drives pins via control bits
`timescale 1ns/1ps
`include "eeprom_params.svh"
module eeprom_target #(
	parameter int ADDR_W = `ADDR_W,
	parameter logic [15:0] WRITE_CYCLES = `WRITE_CYCLES
)(
	input wire logic clock,
	input wire logic rst,
	eeprom_bus_if.target bus,
	output logic busy_ff
);
	localparam int PL = `PAGE_LOW_W;
	localparam int PAGE = 1 << PL;
	localparam int DW = `DATA_W;

	logic [1:0] scl_sync_ff;
	logic [1:0] sda_sync_ff;
	logic scl_prev_ff;
	logic sda_prev_ff;
	logic scl_h;
	logic sda_s;
	logic scl_rise;
	logic scl_fall;
	logic start_seen;
	logic stop_seen;

	eeprom_pkg::target_state_t state_ff;
	eeprom_pkg::target_state_t nxt_state;
	logic [3:0] bit_ff;
	logic [3:0] nxt_bit;
	logic [DW-1:0] shift_ff;
	logic [DW-1:0] nxt_shift;
	logic [ADDR_W-1:0] ptr_ff;
	logic [ADDR_W-1:0] nxt_ptr;
	logic drive_ff;
	logic nxt_drive;
	logic [15:0] busy_cnt_ff;
	logic [15:0] nxt_busy_cnt;
	logic [PAGE-1:0] pvalid_ff;
	logic [PAGE-1:0] nxt_pvalid;
	logic line_lo_ff;
	logic buf_we;
	logic commit;
	logic [DW-1:0] pbuf [PAGE];
	logic [DW-1:0] mem [1 << ADDR_W];
	logic [DW-1:0] rd_byte;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			scl_sync_ff <= 2'h3;
			sda_sync_ff <= 2'h3;
			scl_prev_ff <= 1'b1;
			sda_prev_ff <= 1'b1;
		end
		else
		begin
			scl_sync_ff <= {scl_sync_ff[0], bus.scl};
			sda_sync_ff <= {sda_sync_ff[0], bus.sda};
			scl_prev_ff <= scl_sync_ff[1];
			sda_prev_ff <= sda_sync_ff[1];
		end
	end

	assign scl_h = scl_sync_ff[1];
	assign sda_s = sda_sync_ff[1];
	assign scl_rise = scl_h && !scl_prev_ff;
	assign scl_fall = !scl_h && scl_prev_ff;
	assign start_seen = scl_h && scl_prev_ff && sda_prev_ff && !sda_s;
	assign stop_seen = scl_h && scl_prev_ff && !sda_prev_ff && sda_s;
	assign rd_byte = mem[ptr_ff];

	always_comb
	begin
		nxt_state = state_ff;
		nxt_bit = bit_ff;
		nxt_shift = shift_ff;
		nxt_ptr = ptr_ff;
		nxt_drive = drive_ff;
		nxt_pvalid = pvalid_ff;
		nxt_busy_cnt = busy_cnt_ff - {15'h0000, busy_cnt_ff != 16'h0000};
		buf_we = 1'b0;
		commit = 1'b0;
		if (!bus.power_en)
		begin
			nxt_state = eeprom_pkg::T_IDLE;
			nxt_drive = 1'b0;
			nxt_pvalid = '0;
		end
		else if (start_seen)
		begin
			// Unstopped write is dropped; pointer stays loaded
			nxt_state = eeprom_pkg::T_CTRL;
			nxt_bit = 4'h0;
			nxt_drive = 1'b0;
			nxt_pvalid = '0;
		end
		else if (stop_seen)
		begin
			nxt_state = eeprom_pkg::T_IDLE;
			nxt_drive = 1'b0;
			if (|pvalid_ff)
			begin
				commit = 1'b1;
				nxt_pvalid = '0;
				nxt_busy_cnt = WRITE_CYCLES;
			end
		end
		else if (state_ff != eeprom_pkg::T_IDLE)
		begin
			if (scl_rise)
			begin
				if (bit_ff < `BYTE_LAST_BIT)
				begin
					nxt_bit = bit_ff + 4'h1;
					if (state_ff != eeprom_pkg::T_RDATA)
						nxt_shift = {shift_ff[DW-2:0], sda_s};
				end
				else if (state_ff == eeprom_pkg::T_MACK && sda_s)
				begin
					// No acknowledge from master ends transmission
					nxt_state = eeprom_pkg::T_IDLE;
					nxt_drive = 1'b0;
				end
			end
			else if (scl_fall)
			begin
				if ((state_ff == eeprom_pkg::T_RDATA && bit_ff == `ACK_SLOT)
					|| state_ff == eeprom_pkg::T_MACK)
				begin
					nxt_shift = rd_byte;
					nxt_drive = !rd_byte[DW-1];
					nxt_ptr = ptr_ff + 1'b1;
					nxt_bit = 4'h0;
					nxt_state = eeprom_pkg::T_RDATA;
				end
				else if (state_ff == eeprom_pkg::T_RDATA)
				begin
					if (bit_ff == `BYTE_LAST_BIT)
					begin
						nxt_drive = 1'b0;
						nxt_bit = `ACK_SLOT;
						nxt_state = eeprom_pkg::T_MACK;
					end
					else if (bit_ff != 4'h0)
					begin
						nxt_shift = {shift_ff[DW-2:0], 1'b0};
						nxt_drive = !shift_ff[DW-2];
					end
				end
				else if (bit_ff == `BYTE_LAST_BIT)
				begin
					nxt_bit = `ACK_SLOT;
					unique case (state_ff)
						eeprom_pkg::T_CTRL:
						begin
							// Don't-care bits 3..1 are ignored
							if (shift_ff[DW-1:DW-4] == `DEV_CODE
								&& busy_cnt_ff == 16'h0000)
							begin
								nxt_drive = 1'b1;
								nxt_state = shift_ff[0] ? eeprom_pkg::T_RDATA
									: eeprom_pkg::T_ADDR;
							end
							else
								nxt_state = eeprom_pkg::T_IDLE;
						end
						eeprom_pkg::T_ADDR:
						begin
							nxt_ptr = shift_ff[ADDR_W-1:0];
							nxt_drive = 1'b1;
							nxt_state = eeprom_pkg::T_WDATA;
						end
						eeprom_pkg::T_WDATA:
						begin
							buf_we = 1'b1;
							nxt_pvalid[ptr_ff[PL-1:0]] = 1'b1;
							nxt_ptr = {ptr_ff[ADDR_W-1:PL], ptr_ff[PL-1:0] + 3'h1};
							nxt_drive = 1'b1;
						end
						default:
						begin
							nxt_state = eeprom_pkg::T_IDLE;
						end
					endcase
				end
				else if (bit_ff == `ACK_SLOT)
				begin
					nxt_drive = 1'b0;
					nxt_bit = 4'h0;
				end
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			state_ff <= eeprom_pkg::T_IDLE;
			bit_ff <= 4'h0;
			shift_ff <= 8'h00;
			ptr_ff <= '0;
			drive_ff <= 1'b0;
			busy_cnt_ff <= 16'h0000;
			pvalid_ff <= '0;
			busy_ff <= 1'b0;
			line_lo_ff <= 1'b0;
		end
		else
		begin
			state_ff <= nxt_state;
			bit_ff <= nxt_bit;
			shift_ff <= nxt_shift;
			ptr_ff <= nxt_ptr;
			drive_ff <= nxt_drive;
			busy_cnt_ff <= nxt_busy_cnt;
			pvalid_ff <= nxt_pvalid;
			busy_ff <= nxt_busy_cnt != 16'h0000;
			line_lo_ff <= 1'b0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (buf_we)
			pbuf[ptr_ff[PL-1:0]] <= shift_ff;
		for (int i = 0; i < PAGE; i++)
		begin
			if (commit && pvalid_ff[i])
				mem[{ptr_ff[ADDR_W-1:PL], PL'(i)}] <= pbuf[i];
		end
	end

	assign bus.sda_t_o = line_lo_ff;
	assign bus.sda_t_oe = drive_ff;
endmodule

// File: src/eeprom_master.sv
`timescale 1ns/1ps
`include "eeprom_params.svh"
module byte_fifo #(
	parameter int W = `DATA_W,
	parameter int DEPTH = `FIFO_DEPTH
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic [W-1:0] in_data,
	input wire logic in_valid,
	output logic in_ready_ff,
	output logic [W-1:0] out_data,
	output logic out_valid_ff,
	input wire logic out_ready
);
	localparam int AW = $clog2(DEPTH);
	logic [W-1:0] store [DEPTH];
	logic [AW-1:0] wp_ff;
	logic [AW-1:0] rp_ff;
	logic [AW:0] cnt_ff;
	logic push;
	logic pop;
	logic [AW:0] nxt_cnt;

	always_comb
	begin
		push = in_valid && in_ready_ff;
		pop = out_ready && out_valid_ff;
		nxt_cnt = cnt_ff + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			wp_ff <= '0;
			rp_ff <= '0;
			cnt_ff <= '0;
			in_ready_ff <= 1'b1;
			out_valid_ff <= 1'b0;
		end
		else
		begin
			wp_ff <= wp_ff + {{(AW-1){1'b0}}, push};
			rp_ff <= rp_ff + {{(AW-1){1'b0}}, pop};
			cnt_ff <= nxt_cnt;
			in_ready_ff <= nxt_cnt != (AW+1)'(DEPTH);
			out_valid_ff <= nxt_cnt != '0;
		end
	end

	always_ff @(posedge clock)
	begin
		if (push)
			store[wp_ff] <= in_data;
	end

	assign out_data = store[rp_ff];
endmodule

module eeprom_master #(
	parameter logic [7:0] QUARTER = `QUARTER_CYCLES,
	parameter int FIFO_DEPTH = `FIFO_DEPTH
)(
	input wire logic clock,
	input wire logic rst,
	eeprom_bus_if.master bus,
	input wire logic power_on,
	input wire logic cmd_valid,
	input wire logic [1:0] cmd_op,
	input wire logic [7:0] cmd_addr,
	input wire logic [7:0] cmd_len,
	output logic cmd_ready_ff,
	input wire logic [7:0] wr_data,
	input wire logic wr_valid,
	output logic wr_ready_ff,
	output logic [7:0] rd_data_ff,
	output logic rd_valid_ff,
	output logic done_ff,
	output logic nack_ff
);
	logic [1:0] sda_sync_ff;
	logic sda_s;
	logic tick;
	logic [7:0] fifo_data;
	logic fifo_valid;
	logic pop;
	logic [7:0] sel_byte;
	eeprom_pkg::master_state_t st_ff;
	eeprom_pkg::master_state_t nxt_st;
	eeprom_pkg::stage_t stage_ff;
	eeprom_pkg::stage_t nxt_stage;
	eeprom_pkg::op_t op_ff;
	eeprom_pkg::op_t nxt_op;
	logic [7:0] qc_ff;
	logic [7:0] nxt_qc;
	logic [1:0] q_ff;
	logic [1:0] nxt_q;
	logic [3:0] bit_ff;
	logic [3:0] nxt_bit;
	logic [7:0] tx_ff;
	logic [7:0] nxt_tx;
	logic [7:0] rx_ff;
	logic [7:0] nxt_rx;
	logic [7:0] addr_ff;
	logic [7:0] nxt_addr;
	logic [7:0] len_ff;
	logic [7:0] nxt_len;
	logic ackbit_ff;
	logic nxt_ackbit;
	// Bit 0 power, bit 1 data level, bit 2 clock level
	logic [2:0] memory_interface_control_ff;
	logic [2:0] nxt_ctrl;
	logic sda_oe_ff;
	logic nxt_rd_valid;
	logic [7:0] nxt_rd_data;
	logic nxt_done;
	logic nxt_nack;

	byte_fifo #(.W(8), .DEPTH(FIFO_DEPTH)) wr_fifo (
		.clock(clock),
		.rst(rst),
		.in_data(wr_data),
		.in_valid(wr_valid),
		.in_ready_ff(wr_ready_ff),
		.out_data(fifo_data),
		.out_valid_ff(fifo_valid),
		.out_ready(pop)
	);

	always_ff @(posedge clock)
	begin
		if (rst)
			sda_sync_ff <= 2'h3;
		else
			sda_sync_ff <= {sda_sync_ff[0], bus.sda};
	end
	assign sda_s = sda_sync_ff[1];
	assign tick = qc_ff == QUARTER - 8'h01;

	always_comb
	begin
		unique case (stage_ff)
			eeprom_pkg::SEQ_CTRLW: sel_byte = {`DEV_CODE, 3'h0, 1'b0};
			eeprom_pkg::SEQ_CTRLR: sel_byte = {`DEV_CODE, 3'h0, 1'b1};
			eeprom_pkg::SEQ_ADDR: sel_byte = addr_ff;
			default: sel_byte = fifo_data;
		endcase
	end

	always_comb
	begin
		nxt_st = st_ff;
		nxt_stage = stage_ff;
		nxt_op = op_ff;
		nxt_q = q_ff;
		nxt_bit = bit_ff;
		nxt_tx = tx_ff;
		nxt_rx = rx_ff;
		nxt_addr = addr_ff;
		nxt_len = len_ff;
		nxt_ackbit = ackbit_ff;
		nxt_ctrl = {memory_interface_control_ff[2:1], power_on};
		nxt_qc = (st_ff == eeprom_pkg::M_IDLE || tick) ? 8'h00 : qc_ff + 8'h01;
		nxt_rd_valid = 1'b0;
		nxt_rd_data = rd_data_ff;
		nxt_done = 1'b0;
		nxt_nack = nack_ff;
		pop = 1'b0;
		if (st_ff == eeprom_pkg::M_IDLE)
		begin
			if (cmd_valid && cmd_ready_ff)
			begin
				nxt_op = eeprom_pkg::op_t'(cmd_op);
				nxt_addr = cmd_addr;
				nxt_len = cmd_len;
				nxt_nack = 1'b0;
				nxt_stage = eeprom_pkg::op_t'(cmd_op) == eeprom_pkg::OP_CUR_READ
					? eeprom_pkg::SEQ_CTRLR : eeprom_pkg::SEQ_CTRLW;
				nxt_st = eeprom_pkg::M_START;
				nxt_q = 2'h0;
			end
		end
		else if (tick)
		begin
			nxt_q = q_ff + 2'h1;
			if (q_ff == 2'h1)
				nxt_ctrl[2] = 1'b1;
			if (q_ff == 2'h3)
				nxt_ctrl[2] = 1'b0;
			unique case (st_ff)
				eeprom_pkg::M_START:
				begin
					if (q_ff == 2'h0)
						nxt_ctrl[1] = 1'b1;
					if (q_ff == 2'h2)
						nxt_ctrl[1] = 1'b0;
					if (q_ff == 2'h3)
					begin
						nxt_st = eeprom_pkg::M_TX;
						nxt_bit = 4'h0;
					end
				end
				eeprom_pkg::M_TX:
				begin
					if (q_ff == 2'h0)
					begin
						if (bit_ff == 4'h0)
						begin
							if (stage_ff == eeprom_pkg::SEQ_DATA && !fifo_valid)
								nxt_q = q_ff;
							else
							begin
								pop = stage_ff == eeprom_pkg::SEQ_DATA;
								nxt_tx = sel_byte;
								nxt_ctrl[1] = sel_byte[7];
							end
						end
						else if (bit_ff < `BYTE_LAST_BIT)
							nxt_ctrl[1] = tx_ff[3'h7 - bit_ff[2:0]];
						else
							nxt_ctrl[1] = 1'b1;
					end
					if (q_ff == 2'h2 && bit_ff == `BYTE_LAST_BIT)
						nxt_ackbit = sda_s;
					if (q_ff == 2'h3)
					begin
						nxt_bit = bit_ff + 4'h1;
						if (bit_ff == `BYTE_LAST_BIT)
						begin
							nxt_bit = 4'h0;
							if (ackbit_ff)
							begin
								if (op_ff == eeprom_pkg::OP_POLL)
									nxt_st = eeprom_pkg::M_START;
								else
								begin
									nxt_nack = 1'b1;
									nxt_st = eeprom_pkg::M_STOP;
								end
							end
							else
							begin
								unique case (stage_ff)
									eeprom_pkg::SEQ_CTRLW:
									begin
										nxt_stage = eeprom_pkg::SEQ_ADDR;
										if (op_ff == eeprom_pkg::OP_POLL)
											nxt_st = eeprom_pkg::M_STOP;
									end
									eeprom_pkg::SEQ_ADDR:
									begin
										if (op_ff == eeprom_pkg::OP_RAND_READ)
										begin
											nxt_stage = eeprom_pkg::SEQ_CTRLR;
											nxt_st = eeprom_pkg::M_START;
										end
										else
										begin
											nxt_stage = eeprom_pkg::SEQ_DATA;
											if (len_ff == 8'h00)
												nxt_st = eeprom_pkg::M_STOP;
										end
									end
									eeprom_pkg::SEQ_DATA:
									begin
										nxt_len = len_ff - 8'h01;
										if (len_ff <= 8'h01)
											nxt_st = eeprom_pkg::M_STOP;
									end
									default:
									begin
										nxt_stage = eeprom_pkg::SEQ_READ;
										nxt_st = eeprom_pkg::M_RX;
									end
								endcase
							end
						end
					end
				end
				eeprom_pkg::M_RX:
				begin
					if (q_ff == 2'h0)
						nxt_ctrl[1] = bit_ff != `BYTE_LAST_BIT || len_ff <= 8'h01;
					if (q_ff == 2'h2 && bit_ff < `BYTE_LAST_BIT)
					begin
						nxt_rx = {rx_ff[6:0], sda_s};
						if (bit_ff == 4'h7)
						begin
							nxt_rd_data = {rx_ff[6:0], sda_s};
							nxt_rd_valid = 1'b1;
						end
					end
					if (q_ff == 2'h3)
					begin
						nxt_bit = bit_ff + 4'h1;
						if (bit_ff == `BYTE_LAST_BIT)
						begin
							nxt_bit = 4'h0;
							nxt_len = len_ff - 8'h01;
							if (len_ff <= 8'h01)
								nxt_st = eeprom_pkg::M_STOP;
						end
					end
				end
				default:
				begin
					if (q_ff == 2'h0)
						nxt_ctrl[1] = 1'b0;
					if (q_ff == 2'h2)
						nxt_ctrl[1] = 1'b1;
					if (q_ff == 2'h3)
					begin
						nxt_ctrl[2] = 1'b1;
						nxt_st = eeprom_pkg::M_IDLE;
						nxt_done = 1'b1;
					end
				end
			endcase
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			st_ff <= eeprom_pkg::M_IDLE;
			stage_ff <= eeprom_pkg::SEQ_CTRLW;
			op_ff <= eeprom_pkg::OP_WRITE;
			qc_ff <= 8'h00;
			q_ff <= 2'h0;
			bit_ff <= 4'h0;
			tx_ff <= 8'h00;
			rx_ff <= 8'h00;
			addr_ff <= 8'h00;
			len_ff <= 8'h00;
			ackbit_ff <= 1'b1;
			memory_interface_control_ff <= 3'h6;
			sda_oe_ff <= 1'b0;
			cmd_ready_ff <= 1'b0;
			rd_data_ff <= 8'h00;
			rd_valid_ff <= 1'b0;
			done_ff <= 1'b0;
			nack_ff <= 1'b0;
		end
		else
		begin
			st_ff <= nxt_st;
			stage_ff <= nxt_stage;
			op_ff <= nxt_op;
			qc_ff <= nxt_qc;
			q_ff <= nxt_q;
			bit_ff <= nxt_bit;
			tx_ff <= nxt_tx;
			rx_ff <= nxt_rx;
			addr_ff <= nxt_addr;
			len_ff <= nxt_len;
			ackbit_ff <= nxt_ackbit;
			memory_interface_control_ff <= nxt_ctrl;
			sda_oe_ff <= !nxt_ctrl[1];
			cmd_ready_ff <= nxt_st == eeprom_pkg::M_IDLE;
			rd_data_ff <= nxt_rd_data;
			rd_valid_ff <= nxt_rd_valid;
			done_ff <= nxt_done;
			nack_ff <= nxt_nack;
		end
	end

	assign bus.scl = memory_interface_control_ff[2];
	assign bus.sda_m_o = 1'b0;
	assign bus.sda_m_oe = sda_oe_ff;
	assign bus.power_en = memory_interface_control_ff[0];
endmodule

// File: tb/eeprom_serial_chk.sv
`timescale 1ns/1ps
`include "eeprom_params.svh"
module eeprom_serial_chk #(
	parameter logic [15:0] WRITE_CYCLES = `WRITE_CYCLES
)(
	input wire logic clock,
	input wire logic rst,
	input wire logic scl,
	input wire logic sda,
	input wire logic sda_m_oe,
	input wire logic sda_t_o,
	input wire logic sda_t_oe,
	input wire logic power_en,
	input wire logic busy_ff
);
	default clocking cb @(posedge clock); endclocking
	default disable iff (rst);
	logic [15:0] busy_cnt_ff;
	logic [15:0] nxt_busy_cnt;
	always_comb nxt_busy_cnt = busy_ff ? busy_cnt_ff + 16'h0001 : 16'h0000;
	always_ff @(posedge clock) busy_cnt_ff <= rst ? 16'h0000 : nxt_busy_cnt;
	a_target_open_drain: assert property (sda_t_oe |-> !sda_t_o && !sda)
		else $error("target drove data high");
	a_busy_no_ack: assert property (busy_ff |-> !sda_t_oe)
		else $error("target drove data while busy");
	a_stable_while_high: assert property (scl && $past(scl) |-> $stable(sda_t_oe))
		else $error("target changed data while clock high");
	a_change_when_low: assert property ($changed(sda_t_oe) |-> !scl)
		else $error("target data change outside clock low");
	a_release_unpowered: assert property (!power_en |-> !sda_t_oe)
		else $error("target drove data while unpowered");
	a_write_cycle_len: assert property ($fell(busy_ff) |->
		busy_cnt_ff + 16'h0002 >= WRITE_CYCLES && busy_cnt_ff <= WRITE_CYCLES + 16'h0002)
		else $error("write cycle length wrong");
	a_busy_after_stop: assert property ($rose(busy_ff) |-> scl && sda)
		else $error("write cycle began without stop");
	a_scl_high_width: assert property ($rose(scl) |-> scl [*6])
		else $error("clock high phase too short");
	a_no_line_clash: assert property (scl && sda_t_oe |-> !sda_m_oe)
		else $error("both ends drove data");
	c_write_cycle: cover property ($rose(busy_ff));
	c_target_drive: cover property ($rose(sda_t_oe));
	c_master_ack: cover property (scl && sda_m_oe && !busy_ff);
endmodule

// File: tb/test_serial_eeprom_protocol_target.sv
`timescale 1ns/1ps
`include "eeprom_params.svh"
module test_serial_eeprom_protocol_target;
	localparam logic [15:0] WC = 16'h0258;
	logic clock = 1'b0;
	logic rst = 1'b1;
	logic power_on = 1'b1;
	logic cmd_valid = 1'b0;
	logic wr_valid = 1'b0;
	logic [1:0] cmd_op = 2'h0;
	logic [7:0] cmd_addr = 8'h00;
	logic [7:0] cmd_len = 8'h00;
	logic [7:0] wr_data = 8'h00;
	logic [7:0] rd_data_ff, sh, ctl_seen, ptr;
	logic cmd_ready_ff, wr_ready_ff, rd_valid_ff, done_ff, nack_ff, busy_ff, first;
	logic [7:0] mem [256];
	logic [7:0] expq [$];
	logic [7:0] wq [$];
	logic [31:0] seed = 32'hf6824b6b;
	int mismatches = 0;
	int n_checks = 0;
	int cycles = 0;
	int nbits = 0;
	eeprom_bus_if bus();
	eeprom_master u_eeprom_master(.clock(clock), .rst(rst), .bus(bus.master),
		.power_on(power_on), .cmd_valid(cmd_valid), .cmd_op(cmd_op), .cmd_addr(cmd_addr),
		.cmd_len(cmd_len), .cmd_ready_ff(cmd_ready_ff), .wr_data(wr_data),
		.wr_valid(wr_valid), .wr_ready_ff(wr_ready_ff), .rd_data_ff(rd_data_ff),
		.rd_valid_ff(rd_valid_ff), .done_ff(done_ff), .nack_ff(nack_ff));
	eeprom_target #(.WRITE_CYCLES(WC)) u_eeprom_target(.clock(clock), .rst(rst),
		.bus(bus.target), .busy_ff(busy_ff));
	eeprom_serial_chk #(.WRITE_CYCLES(WC)) u_eeprom_serial_chk(.clock(clock), .rst(rst),
		.scl(bus.scl), .sda(bus.sda), .sda_m_oe(bus.sda_m_oe), .sda_t_o(bus.sda_t_o),
		.sda_t_oe(bus.sda_t_oe), .power_en(bus.power_en), .busy_ff(busy_ff));
	always #2 clock = ~clock;
	function automatic logic [7:0] rnd();
		seed ^= seed << 13;
		seed ^= seed >> 17;
		seed ^= seed << 5;
		return seed[7:0];
	endfunction
	task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
		n_checks++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic tally_and_finish();
		$display("checks %0d mismatches %0d", n_checks, mismatches);
		if (mismatches == 0 && n_checks > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 60000)
		begin
			mismatches++;
			tally_and_finish();
		end
	end
	// Control byte seen on the wire after each start
	always @(negedge bus.sda)
		if (bus.scl === 1'b1)
		begin
			nbits = 0;
			first = 1'b1;
		end
	always @(posedge bus.scl)
	begin
		nbits++;
		if (nbits <= 8)
			sh = {sh[6:0], bus.sda};
		if (nbits == 8 && first === 1'b1)
			ctl_seen = sh;
		if (nbits == 9)
		begin
			nbits = 0;
			first = 1'b0;
		end
	end
	// Each read byte against the oldest note
	always @(negedge clock)
		if (rd_valid_ff === 1'b1)
		begin
			check("pending reads", {7'h0, expq.size() != 0}, 8'h01);
			if (expq.size() != 0)
				check("read byte", rd_data_ff, expq.pop_front());
		end
	task automatic push(input int n);
		for (int i = 0; i < n; i++)
		begin
			wr_data = rnd();
			wq.push_back(wr_data);
			wr_valid = 1'b1;
			@(posedge clock);
			#1;
		end
		wr_valid = 1'b0;
	endtask
	task automatic run(input logic [1:0] o, input logic [7:0] a, input logic [7:0] n,
		input logic nk);
		int i;
		if (o == eeprom_pkg::OP_RAND_READ)
			ptr = a;
		if (o == eeprom_pkg::OP_WRITE && !nk)
		begin
			for (i = 0; i < n; i++)
				mem[{a[7:3], a[2:0] + 3'(i)}] = wq.pop_front();
			ptr = {a[7:3], a[2:0] + n[2:0]};
		end
		if (o == eeprom_pkg::OP_CUR_READ || o == eeprom_pkg::OP_RAND_READ)
			for (i = 0; i < n; i++)
			begin
				expq.push_back(mem[ptr]);
				ptr++;
			end
		for (i = 0; i < 5000 && cmd_ready_ff !== 1'b1; i++)
			@(posedge clock) #1;
		check("command ready", {7'h0, cmd_ready_ff}, 8'h01);
		cmd_op = o;
		cmd_addr = a;
		cmd_len = n;
		cmd_valid = 1'b1;
		@(posedge clock);
		#1 cmd_valid = 1'b0;
		for (i = 0; i < 20000 && done_ff !== 1'b1; i++)
			@(posedge clock) #1;
		check("operation done", {7'h0, done_ff}, 8'h01);
		check("missing ack", {7'h0, nack_ff}, {7'h0, nk});
		check("control byte", ctl_seen, {`DEV_CODE, 3'h0, o[0] ^ o[1]});
		check("idle lines", {6'h0, bus.scl, bus.sda}, 8'h03);
	endtask
	initial
	begin
		repeat (2) @(posedge clock);
		#1 rst = 1'b0;
		push(2);
		run(eeprom_pkg::OP_WRITE, 8'h40, 8'h02, 1'b0);
		repeat (8) @(posedge clock);
		check("busy", {7'h0, busy_ff}, 8'h01);
		run(eeprom_pkg::OP_WRITE, 8'h10, 8'h00, 1'b1);
		run(eeprom_pkg::OP_POLL, 8'h00, 8'h00, 1'b0);
		push(16);
		check("fifo full", {7'h0, wr_ready_ff}, 8'h00);
		run(eeprom_pkg::OP_WRITE, 8'h3e, 8'h10, 1'b0);
		run(eeprom_pkg::OP_POLL, 8'h00, 8'h00, 1'b0);
		run(eeprom_pkg::OP_CUR_READ, 8'h00, 8'h02, 1'b0);
		run(eeprom_pkg::OP_RAND_READ, 8'h3f, 8'h03, 1'b0);
		run(eeprom_pkg::OP_WRITE, 8'h3e, 8'h00, 1'b0);
		// Power cycle between commands; pointer must survive it
		power_on = 1'b0;
		repeat (4) @(posedge clock);
		#1 check("released unpowered", {7'h0, bus.sda}, 8'h01);
		power_on = 1'b1;
		repeat (2) @(posedge clock) #1;
		run(eeprom_pkg::OP_CUR_READ, 8'h00, 8'h01, 1'b0);
		repeat (20) @(posedge clock);
		check("reads left", 8'(expq.size()), 8'h00);
		tally_and_finish();
	end
endmodule
